/* hw/pmsa_addr_decode.v */
/*
 Three-level strap decoder: turns three strap states into a 7-bit slave
 address. Assumes strap states are already stable and encoded.
*/
`default_nettype none
`include "pmsa_map.vh"
module pmsa_addr_decode (
	input  wire [1:0] strap_lsb,
	input  wire [1:0] strap_mid,
	input  wire [1:0] strap_msb,
	output reg  [6:0] addr
);
	reg [4:0] idx;
	always @* begin
		idx  = 5'd9 * {3'h0, strap_msb} + 5'd3 * {3'h0, strap_mid} + {3'h0, strap_lsb}; // RULE3
		if (idx < `PMSA_IDX_B)
			addr = `PMSA_BASE_A + {2'h0, idx}; // RULE3
		else if (idx < `PMSA_IDX_C)
			addr = `PMSA_BASE_B + {2'h0, idx - `PMSA_IDX_B};
		else
			addr = `PMSA_BASE_C + {2'h0, idx - `PMSA_IDX_C};
	end
endmodule // pmsa_addr_decode
`default_nettype wire

/* hw/pmsa_map.vh */
/*
 Constants for the management-port slave address and bus timing block.
 Assumes a 20 MHz system clock; times are given in their own unit and
 converted to cycles here.
*/
`ifndef PMSA_MAP_VH
`define PMSA_MAP_VH
`define PMSA_CLK_KHZ          20000
`define PMSA_TIMEOUT_MS       25
`define PMSA_TIMEOUT_MAX_MS   35
`define PMSA_STRETCH_MS       25
`define PMSA_TIMEOUT_CYC      24'd500000
`define PMSA_STRETCH_CYC      24'd500000
`define PMSA_STRAP_OPEN       2'd0
`define PMSA_STRAP_LOW        2'd1
`define PMSA_STRAP_HIGH       2'd2
`define PMSA_BASE_A           7'h40
`define PMSA_BASE_B           7'h10
`define PMSA_BASE_C           7'h50
`define PMSA_IDX_B            5'd8
`define PMSA_IDX_C            5'd16
`define PMSA_ADDR_RESET       7'h00
`define PMSA_STRETCH_CYCLES   4'd4
`endif

/* hw/pmsa_slave.v */
/*
 Slave address match and bus timing supervision for a management port.
 Latches strap address after enable and supplies leave reset, watches the
 bus, acknowledges its own address, stretches the clock after each
 acknowledged byte and limits that stretch, and resets on clock-low timeout.
 Assumes open-drain pins resolved outside; straps given as driven-high,
 driven-low indicators per pin (open when neither).
*/
`default_nettype none
`include "pmsa_map.vh"
// Behaviour
// (RULE1) Each strap pin reads as open, low or high, giving 27 choices.
// (RULE2) Straps latched only once enable high and both supplies out of reset.
// (RULE3) Index open<low<high, msb strap heaviest; 0-7,8-15,16-26 to three ranges.
// (RULE4) Decoded value is the 7-bit address; eighth bit is direction.
// (RULE5) Bus clock 10 to 400 kHz; device works across that range.
// (RULE6) Clock low over 25 ms is timeout; interface reset before 35 ms.
// (RULE7) Total slave clock stretch per message kept within 25 ms.
// (RULE8) Master extends clock low at most 10 ms per byte.
// (RULE9) Master leaves at least 1.3 us bus free between stop and start.
// (RULE10) Master clock low at least 1.5 us and high at least 0.6 us; pmsa_master's bit clock is 4 cycles (200 ns) low and 4 high.
// (RULE11) Host encodes X as (mX+b)*10^R in a 16-bit signed word.
// (RULE12) Host decodes Y as (Y*10^-R - b)/m; m,b 16-bit, R 8-bit.
// (RULE13) Slope m held in -32768..32767, decimal shift kept as R.
// (RULE14) Over stretch allowance, release clock and data and return to idle.
// (RULE15) Acknowledge only own latched address; leave data released otherwise.
module pmsa_slave #(
	parameter [23:0] TIMEOUT_CYC = `PMSA_TIMEOUT_CYC,
	parameter [23:0] STRETCH_CYC = `PMSA_STRETCH_CYC
) (
	input  wire       sys_clk,
	input  wire       rstn,
	input  wire       enable,
	input  wire       vdd_por_done,
	input  wire       vref_por_done,
	input  wire       strap_lsb_hi,
	input  wire       strap_lsb_lo,
	input  wire       strap_mid_hi,
	input  wire       strap_mid_lo,
	input  wire       strap_msb_hi,
	input  wire       strap_msb_lo,
	input  wire       scl_in,
	output wire       scl_out,
	output wire       scl_oe,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	output reg  [6:0] slave_addr_r,
	output reg        addr_valid_r,
	output reg        addr_match_r,
	output reg        read_dir_r,
	output reg        timeout_r,
	output reg        stretch_abort_r
);
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_ADDR = 5'b00010;
	localparam [4:0] ST_ACK  = 5'b00100;
	localparam [4:0] ST_DATA = 5'b01000;
	localparam [4:0] ST_SKIP = 5'b10000;

	reg        rst_s1_r;
	reg        rst_r;
	reg  [9:0] sync1_r;
	reg  [9:0] sync2_r;
	reg        scl_d_r;
	reg        sda_d_r;
	reg  [4:0] state_r;
	reg  [4:0] state_nxt;
	reg  [3:0] bit_cnt_r;
	reg  [7:0] shift_r;
	reg        ack_drv_r;
	reg        stretch_r;
	reg  [3:0] str_cnt_r;
	reg [23:0] low_cnt_r;
	reg [23:0] stretch_tot_r;
	wire [1:0] st_lsb;
	wire [1:0] st_mid;
	wire [1:0] st_msb;
	wire [6:0] dec_addr;
	wire       scl_s;
	wire       sda_s;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_c;
	wire       stop_c;
	wire       abort;

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_r    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_r    <= rst_s1_r;
		end
	end

	// Two-stage synchronisers for all pins
	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			// Bus lines idle high; enable, supplies and straps read inactive
			sync1_r <= 10'h060;
			sync2_r <= 10'h060;
		end else begin
			sync1_r <= {enable, vdd_por_done, vref_por_done, scl_in, sda_in,
				strap_lsb_hi, strap_lsb_lo, strap_mid_hi, strap_mid_lo, strap_msb_hi};
			sync2_r <= sync1_r;
		end
	end
	reg msb_lo_s1_r;
	reg msb_lo_s2_r;
	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			msb_lo_s1_r <= 1'b0;
			msb_lo_s2_r <= 1'b0;
		end else begin
			msb_lo_s1_r <= strap_msb_lo;
			msb_lo_s2_r <= msb_lo_s1_r;
		end
	end

	assign scl_s  = sync2_r[6];
	assign sda_s  = sync2_r[5];
	assign st_lsb = sync2_r[4] ? `PMSA_STRAP_HIGH :
		(sync2_r[3] ? `PMSA_STRAP_LOW : `PMSA_STRAP_OPEN); // RULE1
	assign st_mid = sync2_r[2] ? `PMSA_STRAP_HIGH :
		(sync2_r[1] ? `PMSA_STRAP_LOW : `PMSA_STRAP_OPEN);
	assign st_msb = sync2_r[0] ? `PMSA_STRAP_HIGH :
		(msb_lo_s2_r ? `PMSA_STRAP_LOW : `PMSA_STRAP_OPEN);

	pmsa_addr_decode u_dec (
		.strap_lsb (st_lsb),
		.strap_mid (st_mid),
		.strap_msb (st_msb),
		.addr      (dec_addr)
	);

	// Latch once per power-up; relatch after enable drops
	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			slave_addr_r <= `PMSA_ADDR_RESET;
			addr_valid_r <= 1'b0;
		end else if (!sync2_r[9]) begin
			addr_valid_r <= 1'b0;
		end else if (!addr_valid_r && sync2_r[8] && sync2_r[7]) begin
			slave_addr_r <= dec_addr; // RULE2
			addr_valid_r <= 1'b1;
		end
	end

	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	// Edge detection at 20 MHz covers bus clocks up to 400 kHz
	assign scl_rise = scl_s & ~scl_d_r; // RULE5
	assign scl_fall = ~scl_s & scl_d_r;
	assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign abort    = timeout_r | stretch_abort_r;

	// Clock-low timeout counter
	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			low_cnt_r <= 24'h000000;
			timeout_r <= 1'b0;
		end else if (scl_s) begin
			low_cnt_r <= 24'h000000;
			timeout_r <= 1'b0;
		end else begin
			if (low_cnt_r != TIMEOUT_CYC)
				low_cnt_r <= low_cnt_r + 24'h000001;
			timeout_r <= (low_cnt_r == TIMEOUT_CYC); // RULE6
		end
	end

	// Cumulative stretch per message
	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			stretch_tot_r   <= 24'h000000;
			stretch_abort_r <= 1'b0;
		end else if (start_c || stop_c || state_r == ST_IDLE) begin
			stretch_tot_r   <= 24'h000000;
			stretch_abort_r <= 1'b0;
		end else if (stretch_r) begin
			stretch_tot_r <= stretch_tot_r + 24'h000001; // RULE7
			if (stretch_tot_r >= STRETCH_CYC)
				stretch_abort_r <= 1'b1; // RULE14
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: if (start_c) state_nxt = ST_ADDR;
		ST_ADDR: if (scl_fall && bit_cnt_r == 4'd8)
				state_nxt = (shift_r[7:1] == slave_addr_r && addr_valid_r) ?
					ST_ACK : ST_SKIP; // RULE15
		ST_ACK:  if (scl_fall) state_nxt = ST_DATA;
		ST_DATA: if (scl_fall && bit_cnt_r == 4'd8) state_nxt = ST_ACK;
		ST_SKIP: state_nxt = ST_SKIP;
		default: state_nxt = ST_IDLE;
		endcase
		if (stop_c)
			state_nxt = ST_IDLE;
		if (start_c)
			state_nxt = ST_ADDR;
		if (abort)
			state_nxt = ST_IDLE; // RULE14
	end

	always @(posedge sys_clk or negedge rst_r) begin
		if (!rst_r) begin
			state_r      <= ST_IDLE;
			bit_cnt_r    <= 4'd0;
			shift_r      <= 8'h00;
			ack_drv_r    <= 1'b0;
			stretch_r    <= 1'b0;
			str_cnt_r    <= 4'd0;
			addr_match_r <= 1'b0;
			read_dir_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (abort || start_c || stop_c) begin
				bit_cnt_r <= 4'd0;
				ack_drv_r <= 1'b0;
				stretch_r <= 1'b0; // RULE6
				if (!start_c)
					addr_match_r <= 1'b0;
			end else begin
				// The acknowledge clock is not a data bit
				if (scl_rise && bit_cnt_r != 4'd8 && state_r != ST_ACK) begin
					shift_r   <= {shift_r[6:0], sda_s};
					bit_cnt_r <= bit_cnt_r + 4'd1;
				end
				if (scl_fall && bit_cnt_r == 4'd8) begin
					bit_cnt_r <= 4'd0;
					if (state_r == ST_ADDR) begin
						addr_match_r <= (state_nxt == ST_ACK);
						read_dir_r   <= shift_r[0]; // RULE4
					end
					ack_drv_r <= (state_nxt == ST_ACK) && !(state_r == ST_DATA && read_dir_r);
				end else if (scl_fall && state_r == ST_ACK) begin
					ack_drv_r <= 1'b0;
					stretch_r <= 1'b1;
					str_cnt_r <= `PMSA_STRETCH_CYCLES;
				end
				if (stretch_r) begin
					str_cnt_r <= str_cnt_r - 4'd1;
					if (str_cnt_r == 4'd1)
						stretch_r <= 1'b0;
				end
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = ack_drv_r & ~abort; // RULE15
	assign scl_out = 1'b0;
	assign scl_oe  = stretch_r & ~abort; // RULE14
endmodule // pmsa_slave
`default_nettype wire

/* verification/pmsa_master.sv */
/* Bus host model driving clock and data enables. Assumes pulled-up lines. */
`default_nettype none
module pmsa_master (
	input  wire logic sys_clk,
	input  wire logic scl,
	input  wire logic sda,
	output var logic  scl_oe = 1'h0,
	output var logic  sda_oe = 1'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	int stalls = 0;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Release clock, wait out a slave stretch for a bounded time
	task automatic up();
		scl_oe <= 1'h0;
		tick(1);
		for (int k = 0; k < 40 && !scl; k++) tick(1);
		if (!scl)
			stalls++;
		tick(3);
	endtask
	// Direct-format value to word; m and b signed 16-bit, R signed 8-bit
	function automatic logic [15:0] to_direct(input int x, input logic signed [15:0] m,
		input logic signed [15:0] b, input logic signed [7:0] r);
		int v;
		v = m * x + b;
		for (int k = 0; k < r; k++)
			v = v * 10;
		for (int k = 0; k > r; k--)
			v = v / 10;
		return v[15:0];
	endfunction
	// Word to real-world value, in thousandths
	function automatic int from_direct(input logic signed [15:0] y, input logic signed [15:0] m,
		input logic signed [15:0] b, input logic signed [7:0] r);
		int v;
		v = y;
		for (int k = 0; k > r; k--)
			v = v * 10;
		for (int k = 0; k < r; k++)
			v = v / 10;
		return (v - b) * 1000 / m;
	endfunction
	task automatic start();
		sda_oe <= 1'h1;
		tick(4);
		scl_oe <= 1'h1;
		tick(4);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		for (int k = 7; k >= 0; k--) begin
			sda_oe <= !b[k];
			tick(2);
			up();
			scl_oe <= 1'h1;
			tick(2);
		end
		sda_oe <= 1'h0;
		tick(2);
		up();
		ack = !sda;
		scl_oe <= 1'h1;
		tick(2);
	endtask
	task automatic stop();
		sda_oe <= 1'h1;
		tick(2);
		up();
		sda_oe <= 1'h0;
		tick(28);
	endtask
endmodule // pmsa_master
`default_nettype wire

/* verification/pmsa_slave_sva.sv */
/* Port checker for pmsa_slave. Assumes it is bound into every instance. */
`default_nettype none
module pmsa_slave_sva #(
	parameter [23:0] TIMEOUT_CYC = 24'd500000
) (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       enable,
	input wire logic       vdd_por_done,
	input wire logic       vref_por_done,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [6:0] slave_addr_r,
	input wire logic       addr_valid_r,
	input wire logic       timeout_r,
	input wire logic       stretch_abort_r
);
	logic [23:0] low_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			low_r <= 24'h0;
		else
			low_r <= scl_in ? 24'h0 : low_r + 24'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_pins_low: assert property (!scl_out && !sda_out) else $error("pin level");
	chk_latch_gate: assert property (
		$rose(addr_valid_r) |-> $past(enable && vdd_por_done && vref_por_done)) else $error("gate");
	chk_addr_range: assert property (addr_valid_r |-> slave_addr_r inside
		{[7'h40:7'h47], [7'h10:7'h17], [7'h50:7'h5a]}) else $error("range");
	chk_ack_valid: assert property (sda_oe |-> addr_valid_r) else $error("ack");
	chk_stretch_len: assert property (
		$rose(scl_oe) |-> scl_oe [*4] ##1 !scl_oe) else $error("stretch");
	chk_tout_quiet: assert property (timeout_r |-> !sda_oe && !scl_oe) else $error("tq");
	chk_abort_quiet: assert property (
		stretch_abort_r |-> !sda_oe && !scl_oe) else $error("abort");
	chk_tout_early: assert property (
		$rose(timeout_r) |-> low_r >= TIMEOUT_CYC && !scl_in) else $error("early");
	chk_tout_late: assert property (
		low_r == TIMEOUT_CYC + 24'd8 |-> timeout_r) else $error("late");
	cover property ($rose(addr_valid_r));
	cover property (sda_oe);
	cover property ($rose(timeout_r));
	cover property ($rose(stretch_abort_r));
endmodule // pmsa_slave_sva
bind pmsa_slave pmsa_slave_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (
	.sys_clk         (sys_clk),
	.rstn            (rstn),
	.enable          (enable),
	.vdd_por_done    (vdd_por_done),
	.vref_por_done   (vref_por_done),
	.scl_in          (scl_in),
	.scl_out         (scl_out),
	.scl_oe          (scl_oe),
	.sda_out         (sda_out),
	.sda_oe          (sda_oe),
	.slave_addr_r    (slave_addr_r),
	.addr_valid_r    (addr_valid_r),
	.timeout_r       (timeout_r),
	.stretch_abort_r (stretch_abort_r)
);
`default_nettype wire

/* verification/pmsa_slave_test.sv */
/* Self-checking bench for pmsa_slave. Assumes pull-ups on both lines. */
`default_nettype none
module pmsa_slave_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TO = 2000;
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic enable = 1'h0;
	logic vdd_por_done = 1'h0;
	logic vref_por_done = 1'h0;
	logic strap_lsb_hi = 1'h0, strap_lsb_lo = 1'h0, strap_mid_hi = 1'h0;
	logic strap_mid_lo = 1'h0, strap_msb_hi = 1'h0, strap_msb_lo = 1'h0;
	wire scl_out, scl_oe, sda_out, sda_oe, addr_valid_r, addr_match_r, read_dir_r;
	wire timeout_r, stretch_abort_r, m_scl, m_sda;
	wire [6:0] slave_addr_r;
	wire scl_in = !(scl_oe || m_scl);
	wire sda_in = !(sda_oe || m_sda);
	int mismatches = 0;
	int check_count = 0;
	int i;
	logic ack;
	// Strap index beside the address it selects
	logic [11:0] rows [6] = '{{5'h0, 7'h40}, {5'h7, 7'h47}, {5'h8, 7'h10},
		{5'hd, 7'h15}, {5'h10, 7'h50}, {5'h1a, 7'h5a}};
	always #25 sys_clk = ~sys_clk;
	pmsa_slave #(.TIMEOUT_CYC(24'd2000), .STRETCH_CYC(24'd11)) dut (.*);
	pmsa_master host (.sys_clk(sys_clk), .scl(scl_in), .sda(sda_in), .scl_oe(m_scl),
		.sda_oe(m_sda));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [1:0] enc(input int s);
		return {s == 2, s == 1};
	endfunction
	task automatic relatch(input int n);
		enable <= 1'h0;
		{strap_msb_hi, strap_msb_lo, strap_mid_hi, strap_mid_lo, strap_lsb_hi, strap_lsb_lo}
			<= {enc(n / 9), enc(n / 3 % 3), enc(n % 3)};
		repeat (8) @(posedge sys_clk);
		enable <= 1'h1;
		repeat (6) @(posedge sys_clk);
		for (i = 0; i < 40 && addr_valid_r !== 1'h1; i++) @(posedge sys_clk);
		if (i == 40) begin
			mismatches++;
			end_sim();
		end
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		rstn <= 1'h1;
		vdd_por_done <= 1'h1;
		enable <= 1'h1;
		repeat (20) @(posedge sys_clk);
		check(addr_valid_r, 8'h0);
		vref_por_done <= 1'h1;
		for (int r = 0; r < 6; r++) begin
			relatch(rows[r][11:7]);
			check(slave_addr_r, rows[r][6:0]);
		end
		check(host.to_direct(2, 16'sd6904, -16'sd185, -8'sd1), 16'd1362);
		check(16'(host.from_direct(16'sd2743, 16'sd6904, -16'sd185, -8'sd1)), 16'd3999);
		host.start();
		host.send(8'hb4, ack);
		check(ack, 8'h1);
		check(addr_match_r, 8'h1);
		host.send(8'h3c, ack);
		check(ack, 8'h1);
		host.stop();
		host.start();
		host.send(8'hb5, ack);
		check(read_dir_r, 8'h1);
		host.stop();
		host.start();
		host.send(8'hb6, ack);
		check(ack, 8'h0);
		host.stop();
		host.start();
		for (i = 0; i < TO + 40 && timeout_r !== 1'h1; i++) @(posedge sys_clk);
		check(i > TO - 8 && i < TO + 8, 8'h1);
		host.stop();
		check(timeout_r, 8'h0);
		host.start();
		host.send(8'hb4, ack);
		check(ack, 8'h1);
		host.stop();
		host.start();
		host.send(8'hb4, ack);
		host.send(8'h01, ack);
		host.send(8'h02, ack);
		check(ack, 8'h1);
		host.send(8'h03, ack);
		check(ack, 8'h0);
		check(addr_match_r, 8'h0);
		host.stop();
		rstn <= 1'h0;
		repeat (2) @(posedge sys_clk);
		check(addr_valid_r, 8'h0);
		rstn <= 1'h1;
		relatch(0);
		check(slave_addr_r, 8'h40);
		check(16'(host.stalls), 16'h0);
		end_sim();
	end
endmodule // pmsa_slave_test
`default_nettype wire
